// ---- logic/psdm_monitor.sv ----
/*
  Pulse speed deviation monitor: measures a speed from pulses on a pin,
  scales it, compares it with the motor speed and raises alarms or faults.
  Assumes an APB master on the same clock and a motor speed in rpm that is
  synchronous to this clock; the pulse pin is asynchronous.
*/
`timescale 1ns/100ps
module psdm_monitor
  import psdm_pkg::*;
#(
  parameter int TICK_CYCLES = CYCLES_PER_MS  // Clocks per 1 ms tick
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Pulse transmitter pin, asynchronous
  input  wire logic        pulseIn,
  // Drive speeds, rpm
  input  wire logic [15:0] motorSpeedActual,
  input  wire logic [15:0] altSpeedSource,
  // Results
  output logic [15:0]      measuredPulseSpeed,
  output logic             alarmSpeedLow,
  output logic             alarmSpeedHigh,
  output logic             alarmSpeedOutOfBand,
  output logic             faultSpeedLow,
  output logic             faultSpeedHigh,
  output logic             faultSpeedOutOfBand
);

  // One-hot message index from a response code: low, high, band
  function automatic logic [2:0] respOneHot(input logic [2:0] resp);
    unique case (resp)
      3'h1, 3'h4: respOneHot = 3'b001;
      3'h2, 3'h5: respOneHot = 3'b010;
      3'h3, 3'h6: respOneHot = 3'b100;
      default:    respOneHot = 3'b000;
    endcase
  endfunction : respOneHot

  // Settings
  logic [2:0]  resp_r, resp_nxt;          // monitorResponseSelect
  logic        edge_r, edge_nxt;          // pulseEdgeSelect
  logic [1:0]  mcfg_r, mcfg_nxt;          // monitorConfigSelect
  logic [15:0] ppr_r, ppr_nxt;            // pulsesPerRevolution
  logic [15:0] gear_r, gear_nxt;          // pulseGearFactor
  logic [15:0] maxt_r, maxt_nxt;          // maxMeasureTime, ms
  logic [15:0] dly_r, dly_nxt;            // monitorDelayTime, ms
  logic [15:0] dev_r, dev_nxt;            // allowedSpeedDeviation, rpm
  logic        src_r, src_nxt;            // monitoredSpeedSource
  // Bus answer
  logic [31:0] rdata_r, rdata_nxt;
  logic        err_r, err_nxt;
  // Pin synchroniser and edge history
  logic        sync1_r, sync2_r, sync3_r;
  // Measurement
  logic [31:0] tickCnt_r, tickCnt_nxt;    // Millisecond prescaler
  logic [31:0] ival_r, ival_nxt;          // Cycles since last edge
  logic [15:0] msSince_r, msSince_nxt;    // Ms since last edge
  logic        havePrev_r, havePrev_nxt;  // Interval start is known
  logic        tout_r, tout_nxt;          // Timed out, speed forced zero
  logic [15:0] speed_r, speed_nxt;        // measuredPulseSpeed
  // Monitoring
  logic [15:0] violMs_r, violMs_nxt;      // Violation duration, ms
  logic [2:0]  alarm_r, alarm_nxt;
  logic [2:0]  fault_r, fault_nxt;
  // Combinational helpers
  logic            tick, pulseEdge, divStart, divBusy, divDone;
  logic [DIV_W-1:0] divNum, divDen, divQuot;
  logic [15:0]     monSpeed;
  logic [16:0]     monPlusDev, motPlusDev;
  logic            belowBand, aboveBand, enabled, viol, expired;
  logic [2:0]      respHot, faultClr;
  logic            wrEn, rdSetup;

  // APB decode: zero wait states, read data captured in the setup cycle, write data in the access cycle
  assign pready  = 1'b1;
  assign wrEn    = psel && penable && pwrite;
  assign rdSetup = psel && !penable;
  assign prdata  = rdata_r;
  assign pslverr = err_r;
  assign faultClr = (wrEn && paddr == OFS_STAT) ? pwdata[STAT_FAULT_LSB +: 3] : 3'b000;

  // Register writes and read mux
  always_comb begin
    {resp_nxt, edge_nxt, mcfg_nxt} = {resp_r, edge_r, mcfg_r};
    {ppr_nxt, gear_nxt, maxt_nxt}  = {ppr_r, gear_r, maxt_r};
    {dly_nxt, dev_nxt, src_nxt}    = {dly_r, dev_r, src_r};
    rdata_nxt = rdata_r;
    err_nxt   = err_r;
    if (wrEn) begin
      unique case (paddr)
        OFS_CFG: begin
          resp_nxt = pwdata[CFG_RESP_LSB +: 3];
          edge_nxt = pwdata[CFG_EDGE_BIT];
          mcfg_nxt = pwdata[CFG_MCFG_LSB +: 2];
        end
        OFS_PPR:  ppr_nxt  = pwdata[15:0];
        OFS_GEAR: gear_nxt = pwdata[15:0];
        OFS_MAXT: maxt_nxt = pwdata[15:0];
        OFS_DLY:  dly_nxt  = pwdata[15:0];
        OFS_DEV:  dev_nxt  = pwdata[15:0];
        OFS_SRC:  src_nxt  = pwdata[0];
        default: ;  // Status clears faults, speed is read only
      endcase
    end
    if (rdSetup) begin
      rdata_nxt = 32'h0;
      err_nxt   = 1'b0;
      unique case (paddr)
        OFS_CFG: begin
          rdata_nxt[CFG_RESP_LSB +: 3] = resp_r;
          rdata_nxt[CFG_EDGE_BIT]      = edge_r;
          rdata_nxt[CFG_MCFG_LSB +: 2] = mcfg_r;
        end
        OFS_PPR:   rdata_nxt[15:0] = ppr_r;
        OFS_GEAR:  rdata_nxt[15:0] = gear_r;
        OFS_MAXT:  rdata_nxt[15:0] = maxt_r;
        OFS_DLY:   rdata_nxt[15:0] = dly_r;
        OFS_DEV:   rdata_nxt[15:0] = dev_r;
        OFS_SRC:   rdata_nxt[0]    = src_r;
        OFS_STAT: begin
          rdata_nxt[STAT_ALARM_LSB +: 3] = alarm_r;
          rdata_nxt[STAT_FAULT_LSB +: 3] = fault_r;
          rdata_nxt[STAT_VIOL_BIT]       = viol;
          rdata_nxt[STAT_TOUT_BIT]       = tout_r;
        end
        OFS_SPEED: rdata_nxt[15:0] = speed_r;
        default:   err_nxt = 1'b1;  // Unmapped: error, reads zero
      endcase
    end
  end

  // Register file and bus answer
  always_ff @(posedge clock) begin
    if (reset) begin
      {resp_r, edge_r, mcfg_r} <= {RST_RESP, RST_EDGE, RST_MCFG};
      {ppr_r, gear_r, maxt_r}  <= {RST_PPR, RST_GEAR, RST_MAXT};
      {dly_r, dev_r, src_r}    <= {RST_DLY, RST_DEV, RST_SRC};
      rdata_r <= 32'h0;
      err_r   <= 1'b0;
    end else begin
      {resp_r, edge_r, mcfg_r} <= {resp_nxt, edge_nxt, mcfg_nxt};
      {ppr_r, gear_r, maxt_r}  <= {ppr_nxt, gear_nxt, maxt_nxt};
      {dly_r, dev_r, src_r}    <= {dly_nxt, dev_nxt, src_nxt};
      rdata_r <= rdata_nxt;
      err_r   <= err_nxt;
    end
  end

  // Two-flop synchroniser, third flop only keeps edge history
  always_ff @(posedge clock) begin
    if (reset) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= pulseIn;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Counted edge per edge select
  assign pulseEdge = edge_r ? (sync3_r && !sync2_r) : (sync2_r && !sync3_r);
  assign tick      = (tickCnt_r == 32'(TICK_CYCLES - 1));

  // Rpm = 60 * fclk * gear / (interval * pulses); zero pulses act as one
  assign divNum   = DIV_W'(RPM_NUM) * DIV_W'(gear_r);
  assign divDen   = DIV_W'(ival_r) * DIV_W'((ppr_r == 16'h0) ? 16'h1 : ppr_r);
  // A pulse while the divider runs starts no division, only a new interval; 32 kHz leaves ample margin
  assign divStart = pulseEdge && havePrev_r && !tout_r && !divBusy;

  psdm_divider #(.W(DIV_W)) u_psdm_divider (
    .clock    (clock),
    .reset    (reset),
    .start    (divStart),
    .dividend (divNum),
    .divisor  (divDen),
    .busy     (divBusy),
    .done     (divDone),
    .quotient (divQuot)
  );

  // Measurement next state: edge wins over a timeout in the same cycle
  always_comb begin
    tickCnt_nxt  = tick ? 32'h0 : tickCnt_r + 32'h1;
    ival_nxt     = (ival_r == 32'hffff_ffff) ? ival_r : ival_r + 32'h1;
    msSince_nxt  = (tick && msSince_r != 16'hffff) ? msSince_r + 16'h1 : msSince_r;
    havePrev_nxt = havePrev_r;
    tout_nxt     = tout_r;
    speed_nxt    = speed_r;
    if (divDone && !tout_r) begin
      // Saturate to the 16-bit speed range
      speed_nxt = (divQuot[DIV_W-1:16] != '0) ? 16'hffff : divQuot[15:0];
    end
    if (pulseEdge) begin
      ival_nxt     = 32'h1;
      msSince_nxt  = 16'h0;
      havePrev_nxt = 1'b1;
      tout_nxt     = 1'b0;
    end else if (!tout_r && msSince_r >= maxt_r) begin
      tout_nxt     = 1'b1;
      speed_nxt    = 16'h0;
      havePrev_nxt = 1'b0;  // Stale interval is discarded
    end
  end

  // Measurement registers
  always_ff @(posedge clock) begin
    if (reset) begin
      tickCnt_r  <= 32'h0;
      ival_r     <= 32'h0;
      msSince_r  <= 16'h0;
      havePrev_r <= 1'b0;
      tout_r     <= 1'b0;
      speed_r    <= 16'h0;
    end else begin
      tickCnt_r  <= tickCnt_nxt;
      ival_r     <= ival_nxt;
      msSince_r  <= msSince_nxt;
      havePrev_r <= havePrev_nxt;
      tout_r     <= tout_nxt;
      speed_r    <= speed_nxt;
    end
  end

  // Band check against the motor speed, widened to avoid overflow
  assign monSpeed   = src_r ? speed_r : altSpeedSource;
  assign monPlusDev = {1'b0, monSpeed} + {1'b0, dev_r};
  assign motPlusDev = {1'b0, motorSpeedActual} + {1'b0, dev_r};
  assign belowBand  = monPlusDev < {1'b0, motorSpeedActual};
  assign aboveBand  = {1'b0, monSpeed} > motPlusDev;
  assign enabled    = (mcfg_r == MCFG_SPEED_DEV) && (resp_r != RESP_OFF);
  assign respHot    = respOneHot(resp_r);
  assign viol       = enabled && ((respHot[0] && belowBand) || (respHot[1] && aboveBand)
                      || (respHot[2] && (belowBand || aboveBand)));
  assign expired    = viol && (violMs_r >= dly_r);

  // Monitoring next state; a fault set wins over its clear
  always_comb begin
    violMs_nxt = violMs_r;
    if (!viol) begin
      violMs_nxt = 16'h0;
    end else if (tick && !expired) begin
      violMs_nxt = violMs_r + 16'h1;
    end
    alarm_nxt = (expired && resp_r <= RESP_LAST_WARN) ? respHot : 3'b000;
    fault_nxt = (fault_r & ~faultClr)
              | ((expired && resp_r > RESP_LAST_WARN) ? respHot : 3'b000);
  end

  // Monitoring registers
  always_ff @(posedge clock) begin
    if (reset) begin
      violMs_r <= 16'h0;
      alarm_r  <= 3'b000;
      fault_r  <= 3'b000;
    end else begin
      violMs_r <= violMs_nxt;
      alarm_r  <= alarm_nxt;
      fault_r  <= fault_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign measuredPulseSpeed  = speed_r;
  assign alarmSpeedLow       = alarm_r[0];
  assign alarmSpeedHigh      = alarm_r[1];
  assign alarmSpeedOutOfBand = alarm_r[2];
  assign faultSpeedLow       = fault_r[0];
  assign faultSpeedHigh      = fault_r[1];
  assign faultSpeedOutOfBand = fault_r[2];

  // Checks on the block's own behaviour
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_timeout_zero: assert property (
    tout_r |-> speed_r == 16'h0) else $error("Speed not zero after timeout");
  a_timer_restart: assert property (
    pulseEdge |=> msSince_r == 16'h0 && !tout_r) else $error("Timeout not restarted");
  a_no_msg_off: assert property (
    (resp_r == RESP_OFF)[*2] |-> alarm_r == 3'b000 && !viol) else $error("Message while off");
  a_alarm_class: assert property (
    alarm_r != 3'b000 |-> $past(resp_r) <= RESP_LAST_WARN && $past(expired))
    else $error("Alarm without warning response");
  a_fault_class: assert property (
    $rose(faultSpeedLow) |-> $past(resp_r) == 3'h4 && $past(expired))
    else $error("Low fault from wrong response");
  a_delay_held: assert property (
    $rose(expired) |-> violMs_r >= dly_r && (dly_r == 16'h0 || $past(viol)))
    else $error("Message before delay");
  a_config_gate: assert property (
    mcfg_r != MCFG_SPEED_DEV |-> !viol && !expired) else $error("Monitor active off config");
  a_band_inside: assert property (
    (monPlusDev >= {1'b0, motorSpeedActual} && {1'b0, monSpeed} <= motPlusDev) |-> !viol)
    else $error("Violation inside band");
  a_edge_pick: assert property (
    pulseEdge |-> sync2_r == !edge_r && $past(sync2_r) == edge_r) else $error("Wrong edge");
  a_viol_reset: assert property (
    !viol |=> violMs_r == 16'h0) else $error("Delay timer not cleared");
  a_fault_sticky: assert property (
    fault_r[2] && faultClr[2] == 1'b0 |=> fault_r[2]) else $error("Fault dropped");

  c_timeout:  cover property (!tout_r ##1 tout_r);
  c_speed:    cover property (divDone ##1 speed_r != 16'h0);
  c_alarm:    cover property ($rose(alarmSpeedOutOfBand));
  c_fault:    cover property ($rose(faultSpeedHigh));

endmodule : psdm_monitor

// ---- inc/psdm_pkg.sv ----
/*
  Constants for the pulse speed deviation monitor: register map, field
  positions, reset values and timing counts.
  Assumes a single 40 MHz system clock and a 32-bit APB register bus.
*/
package psdm_pkg;

  // Clock and timing
  localparam logic [63:0] CLOCK_HZ        = 64'h0000_0000_0262_5a00; // 40 MHz
  localparam logic [63:0] MS_PER_S        = 64'h0000_0000_0000_03e8; // 1000
  localparam int          CYCLES_PER_MS   = int'(CLOCK_HZ / MS_PER_S);
  // Numerator of cycles-to-rpm conversion: 60 s per minute times clock rate
  localparam logic [31:0] RPM_NUM         = 32'(64'h3c * CLOCK_HZ);
  localparam logic [63:0] MAX_MEAS_TIME_S = 64'h0a;     // 10 s timeout
  localparam logic [63:0] MON_DELAY_S     = 64'h0a;     // 10 s delay

  // Register byte offsets
  localparam logic [7:0] OFS_CFG   = 8'h00; // Response, edge, monitor config
  localparam logic [7:0] OFS_PPR   = 8'h04; // Pulses per revolution
  localparam logic [7:0] OFS_GEAR  = 8'h08; // Gear factor
  localparam logic [7:0] OFS_MAXT  = 8'h0c; // Max measuring time, ms
  localparam logic [7:0] OFS_DLY   = 8'h10; // Monitor delay, ms
  localparam logic [7:0] OFS_DEV   = 8'h14; // Allowed deviation, rpm
  localparam logic [7:0] OFS_SRC   = 8'h18; // Monitored speed source
  localparam logic [7:0] OFS_STAT  = 8'h1c; // Status, faults write 1 to clear
  localparam logic [7:0] OFS_SPEED = 8'h20; // Measured pulse speed

  // Config field positions
  localparam int CFG_RESP_LSB = 0;  // 3 bits
  localparam int CFG_EDGE_BIT = 4;
  localparam int CFG_MCFG_LSB = 8;  // 2 bits

  // Status field positions
  localparam int STAT_ALARM_LSB = 0;  // 3 bits: low, high, band
  localparam int STAT_FAULT_LSB = 3;  // 3 bits: low, high, band
  localparam int STAT_VIOL_BIT  = 6;
  localparam int STAT_TOUT_BIT  = 7;

  // Field encodings
  localparam logic [1:0] MCFG_SPEED_DEV = 2'h2;  // Deviation plus load failure
  localparam logic [2:0] RESP_OFF       = 3'h0;
  localparam logic [2:0] RESP_LAST_WARN = 3'h3;

  // Reset values
  localparam logic [2:0]  RST_RESP = 3'h0;
  localparam logic        RST_EDGE = 1'b0;
  localparam logic [1:0]  RST_MCFG = 2'h1;
  localparam logic [15:0] RST_PPR  = 16'h0001;
  localparam logic [15:0] RST_GEAR = 16'h0001;
  localparam logic [15:0] RST_MAXT = 16'(MAX_MEAS_TIME_S * MS_PER_S);
  localparam logic [15:0] RST_DLY  = 16'(MON_DELAY_S * MS_PER_S);
  localparam logic [15:0] RST_DEV  = 16'h0096; // 150 rpm
  localparam logic        RST_SRC  = 1'b1;     // Pulse-derived speed

  // Divider width
  localparam int DIV_W = 48;

endpackage : psdm_pkg

// ---- logic/psdm_divider.sv ----
/*
  Sequential restoring divider, one quotient bit per clock.
  Assumes start is a one-cycle pulse given only while busy is low and a
  non-zero divisor; a zero divisor yields an all-ones quotient.
*/
`timescale 1ns/100ps
module psdm_divider
  import psdm_pkg::*;
#(
  parameter int W = DIV_W
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         reset,
  // Request
  input  wire logic         start,
  input  wire logic [W-1:0] dividend,
  input  wire logic [W-1:0] divisor,
  // Answer
  output logic              busy,
  output logic              done,
  output logic [W-1:0]      quotient
);

  logic [W-1:0]         quot_r, quot_nxt;   // Dividend shifts out, quotient in
  logic [W:0]           rem_r, rem_nxt;     // Partial remainder
  logic [W-1:0]         den_r, den_nxt;     // Latched divisor
  logic [$clog2(W):0]   cnt_r, cnt_nxt;     // Bits left
  logic                 done_r, done_nxt;   // Finish pulse
  logic [W:0]           trial;              // Shifted remainder

  // Next state: one shift-subtract step per cycle
  always_comb begin
    quot_nxt = quot_r;
    rem_nxt  = rem_r;
    den_nxt  = den_r;
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    trial    = {rem_r[W-1:0], quot_r[W-1]};
    if (start && cnt_r == '0) begin
      quot_nxt = dividend;
      rem_nxt  = '0;
      den_nxt  = divisor;
      cnt_nxt  = ($clog2(W)+1)'(W);
    end else if (cnt_r != '0) begin
      // Compare against divisor, keep the remainder if it fits
      if (trial >= {1'b0, den_r}) begin
        rem_nxt  = trial - {1'b0, den_r};
        quot_nxt = {quot_r[W-2:0], 1'b1};
      end else begin
        rem_nxt  = trial;
        quot_nxt = {quot_r[W-2:0], 1'b0};
      end
      cnt_nxt  = cnt_r - 1'b1;
      done_nxt = (cnt_r == 1);
    end
  end

  // State registers
  always_ff @(posedge clock) begin
    if (reset) begin
      quot_r <= '0;
      rem_r  <= '0;
      den_r  <= '0;
      cnt_r  <= '0;
      done_r <= 1'b0;
    end else begin
      quot_r <= quot_nxt;
      rem_r  <= rem_nxt;
      den_r  <= den_nxt;
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign busy     = (cnt_r != '0);
  assign done     = done_r;
  assign quotient = quot_r;

endmodule : psdm_divider

// ---- testbench/psdm_pulse_source.sv ----
/*
  Pulse transmitter model: square wave on the pulse pin while run is high.
  Assumes the bench changes run and period just after a rising clock edge.
*/
`timescale 1ns/100ps
module psdm_pulse_source #(
  parameter int MIN_PERIOD = 1250  // Clocks per pulse at 32 kHz and 40 MHz
) (
  // Clock
  input  wire logic        clock,
  // Control from the bench
  input  wire logic        run,
  input  wire logic [15:0] period,
  // Pin towards the monitor
  output logic             pulseIn
);
  logic [15:0] phase_r;    // Clocks into the current period
  logic [15:0] phase_nxt;  // Next phase
  logic [15:0] periodEff;  // Period after the rate limit

  // Next phase; restarts at zero while stopped
  always_comb begin
    // Never faster than the transmitter may go
    periodEff = (period < 16'(MIN_PERIOD)) ? 16'(MIN_PERIOD) : period;
    phase_nxt = phase_r + 16'h0001;
    if (!run || phase_r == periodEff - 16'h0001) begin
      phase_nxt = 16'h0000;
    end
  end

  // Phase register
  always_ff @(posedge clock) begin
    phase_r <= phase_nxt;
  end

  // Switch output pulls low when idle, high in the first half period
  assign pulseIn = run && (phase_r < (periodEff >> 1));
endmodule : psdm_pulse_source

// ---- testbench/psdm_monitor_tb.sv ----
/*
  Self-checking bench for the pulse speed deviation monitor.
  Assumes the design package, the pulse source model and a 4-clock ms tick.
*/
`timescale 1ns/100ps
module psdm_monitor_tb
  import psdm_pkg::*;
;
  localparam int TICK        = 4;      // Shortened ms tick keeps the run brief
  localparam int CYCLE_LIMIT = 60000;  // About twice the expected run
  // Bus, pins and bench state
  logic        clock, reset, psel, penable, pwrite, pready, pslverr, pulseIn, run, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] motorSpeedActual, altSpeedSource, measuredPulseSpeed, period;
  wire  [5:0]  flags;  // Faults band/high/low, alarms band/high/low
  int          errCount, compares, cycleCount;

  psdm_monitor #(.TICK_CYCLES(TICK)) u_psdm_monitor (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pulseIn(pulseIn), .motorSpeedActual(motorSpeedActual), .altSpeedSource(altSpeedSource),
    .measuredPulseSpeed(measuredPulseSpeed), .alarmSpeedLow(flags[0]),
    .alarmSpeedHigh(flags[1]), .alarmSpeedOutOfBand(flags[2]), .faultSpeedLow(flags[3]),
    .faultSpeedHigh(flags[4]), .faultSpeedOutOfBand(flags[5]));

  psdm_pulse_source u_psdm_pulse_source (
    .clock(clock), .run(run), .period(period), .pulseIn(pulseIn));

  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // One APB transfer, request held until pready is seen
  task automatic apbXfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apbXfer

  // Exact compare
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errCount++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Speed compare; one clock of interval slack shifts the quotient a little
  task automatic chkNear(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if ((got + 16'h0004 >= exp && got <= exp + 16'h0004) !== 1'b1) begin
      errCount++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chkNear

  // Alarm and fault outputs together
  task automatic chkFlags(input logic [5:0] exp);
    chk("alarmFaultFlags", {26'h0, exp}, {26'h0, flags});
  endtask : chkFlags

  // Reset values, read-only speed, unmapped address
  task automatic testResetValues;
    logic [7:0]  ofs [9];
    logic [31:0] val [9];
    ofs = '{OFS_CFG, OFS_PPR, OFS_GEAR, OFS_MAXT, OFS_DLY, OFS_DEV, OFS_SRC, OFS_STAT, OFS_SPEED};
    val = '{32'h100, 32'h1, 32'h1, 32'h2710, 32'h2710, 32'h96, 32'h1, 32'h0, 32'h0};
    for (int i = 0; i < 9; i++) begin
      apbXfer(1'b0, ofs[i], 32'h0);
      chk("resetValue", val[i], rd);
      chk("resetSlvErr", 32'h0, {31'h0, err});
    end
    apbXfer(1'b1, OFS_SPEED, 32'hffff);
    apbXfer(1'b0, OFS_SPEED, 32'h0);
    chk("speedReadOnly", 32'h0, rd);
    apbXfer(1'b0, 8'h24, 32'h0);
    chk("unmappedErr", 32'h1, {31'h0, err});
    chk("unmappedData", 32'h0, rd);
  endtask : testResetValues

  // Steady pulses with gear 3, 1000 per turn, then timeout
  task automatic testSpeed;
    apbXfer(1'b1, OFS_PPR, 32'h3e8);
    apbXfer(1'b1, OFS_GEAR, 32'h3);
    apbXfer(1'b1, OFS_MAXT, 32'h3e8);
    period <= 16'h0960;
    run    <= 1'b1;
    repeat (12100) @(posedge clock);
    chkNear("gearedSpeed", 16'h0bb8, measuredPulseSpeed);
    apbXfer(1'b0, OFS_STAT, 32'h0);
    chk("noTimeoutWhilePulsing", 32'h0, {31'h0, rd[7]});
    run <= 1'b0;
    repeat (4500) @(posedge clock);
    chk("speedAfterTimeout", 32'h0, {16'h0, measuredPulseSpeed});
    apbXfer(1'b0, OFS_STAT, 32'h0);
    chk("timeoutFlag", 32'h1, {31'h0, rd[7]});
  endtask : testSpeed

  // Stop mid-high: falling edges 1800 apart, rising 2400 apart
  task automatic testEdge;
    for (int e = 0; e < 2; e++) begin
      apbXfer(1'b1, OFS_CFG, 32'h100 | (32'(e) << 4));
      run <= 1'b1;
      repeat (3000) @(posedge clock);
      run <= 1'b0;
      repeat (200) @(posedge clock);
      chkNear("edgeSpeed", (e == 0) ? 16'h0bb8 : 16'h0fa0, measuredPulseSpeed);
      repeat (4500) @(posedge clock);
    end
  endtask : testEdge

  // Every response below and above the band, then corner cases
  task automatic testMonitor;
    logic [5:0] exp;
    apbXfer(1'b1, OFS_SRC, 32'h0);
    apbXfer(1'b1, OFS_DLY, 32'h5);
    for (int r = 0; r < 8; r++) begin
      for (int h = 0; h < 2; h++) begin
        apbXfer(1'b1, OFS_CFG, 32'h200 | 32'(r));
        altSpeedSource <= (h == 1) ? 16'h04b0 : 16'h0320;
        exp = 6'h00;
        // Low responses skip high cases and the other way round; 7 is inert
        if (r != 0 && r < 7 && (r % 3) != ((h == 1) ? 1 : 2)) begin
          exp = 6'h01 << (r - 1);
        end
        repeat (10) @(posedge clock);
        chkFlags(6'h00);
        repeat (40) @(posedge clock);
        chkFlags(exp);
        altSpeedSource <= 16'h03e8;
        repeat (5) @(posedge clock);
        // Back in band: alarms follow, faults stay latched
        chkFlags(exp & 6'h38);
        apbXfer(1'b1, OFS_STAT, 32'h38);
        repeat (3) @(posedge clock);
        chkFlags(6'h00);
      end
    end
    apbXfer(1'b1, OFS_CFG, 32'h203);
    altSpeedSource <= 16'h0352;
    repeat (50) @(posedge clock);
    chkFlags(6'h00);
    altSpeedSource <= 16'h0351;
    repeat (50) @(posedge clock);
    chkFlags(6'h04);
    altSpeedSource <= 16'h03e8;
    repeat (5) @(posedge clock);
    // Two short excursions must not add up
    altSpeedSource <= 16'h0320;
    repeat (15) @(posedge clock);
    altSpeedSource <= 16'h03e8;
    repeat (3) @(posedge clock);
    altSpeedSource <= 16'h0320;
    repeat (15) @(posedge clock);
    chkFlags(6'h00);
    apbXfer(1'b1, OFS_CFG, 32'h103);
    repeat (50) @(posedge clock);
    chkFlags(6'h00);
    // Pulse speed is zero here, so only the alternate source could trip
    apbXfer(1'b1, OFS_CFG, 32'h203);
    apbXfer(1'b1, OFS_SRC, 32'h1);
    motorSpeedActual <= 16'h0064;
    altSpeedSource   <= 16'h04b0;
    repeat (50) @(posedge clock);
    chkFlags(6'h00);
  endtask : testMonitor

  // Verdict and end of run
  task automatic printVerdict;
    if (errCount == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : printVerdict

  // Main sequence
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    run = 1'b0;
    period = 16'h0960;
    motorSpeedActual = 16'h03e8;
    altSpeedSource = 16'h03e8;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    testResetValues();
    testSpeed();
    testEdge();
    testMonitor();
    printVerdict();
  end

  // Hang guard
  initial begin
    cycleCount = 0;
    while (cycleCount < CYCLE_LIMIT) begin
      @(posedge clock);
      cycleCount++;
    end
    errCount++;
    printVerdict();
  end
endmodule : psdm_monitor_tb
